// ==== verilog/cmsc_consts.svh ====
// Constants for the character-mode channel status and command bank.
// Assumes inclusion by bare name from files under verilog/ and verification/.
`ifndef CMSC_CONSTS_SVH
`define CMSC_CONSTS_SVH

// Word width of every status and command word
`define CMSC_WORD_W          16
// Clock rate, nanoseconds per cycle
`define CMSC_CLK_PERIOD_NS   4
// Exchange durations, in nanoseconds
`define CMSC_STS_TIME_NS     16
`define CMSC_CMD_TIME_NS     16
// Exchange durations, in cycles (least time, rounded up)
`define CMSC_STS_CYCLES      ((`CMSC_STS_TIME_NS + `CMSC_CLK_PERIOD_NS - 1) / `CMSC_CLK_PERIOD_NS)
`define CMSC_CMD_CYCLES      ((`CMSC_CMD_TIME_NS + `CMSC_CLK_PERIOD_NS - 1) / `CMSC_CLK_PERIOD_NS)

// Exchange-progress and exchange-report bit positions
`define CMSC_XB_STATUS       0
`define CMSC_XB_COMMAND      1
`define CMSC_XB_ADJUST       2

// Channel fault word bit positions
`define CMSC_FB_NO_DEVICE    0
`define CMSC_FB_PARTNER      1
`define CMSC_FB_BLOCK        2
`define CMSC_FB_TIMEOUT      3
`define CMSC_FB_INTERNAL     4
`define CMSC_FB_CONFIG       5
`define CMSC_FB_HOST_LINK    6
`define CMSC_FB_APPLICATION  7

// Modem input word bit positions
`define CMSC_MB_CARRIER      0
`define CMSC_MB_CLEAR_SEND   2
`define CMSC_MB_SET_READY    3

// Channel command word bit positions
`define CMSC_CB_CLR_COUNT    0
`define CMSC_CB_READY_ON     8
`define CMSC_CB_READY_OFF    9

// Output command word: halt bit and reboot key
`define CMSC_OB_HALT         0
`define CMSC_REBOOT_KEY      16'hdead

// Protocol status word value in character mode
`define CMSC_PROTOCOL_CHAR   16'h0003

// Reset values
`define CMSC_WORD_RST        16'h0000

`endif

// ==== verilog/cmsc_pkg.sv ====
// Types for the character-mode channel status and command bank.
// Assumes the constants header is on the include path.
`include "cmsc_consts.svh"

package cmsc_pkg;

  // One status or command word
  typedef logic [`CMSC_WORD_W-1:0] cmsc_word_t;

  // Exchange engine states
  typedef enum logic [0:0] {
    CMSC_XS_IDLE = 1'b0,
    CMSC_XS_RUN  = 1'b1
  } cmsc_xstate_t;

endpackage

// ==== verilog/cmsc_fault_counter.sv ====
// Saturating 16-bit counter of character faults with a clear input.
// Assumes event pulses synchronous to clk_sys_in.
`timescale 1ns/1ns

module cmsc_fault_counter
  import cmsc_pkg::*;
(
  input  wire logic       clk_sys_in,   // System clock
  input  wire logic       rst_in,       // Async reset, active high
  input  wire logic       event_in,     // One fault seen this cycle
  input  wire logic       clear_in,     // Clear request
  output cmsc_word_t      count_out     // Current count
);

  cmsc_word_t count_q;  // Count register

  ////////////////////////////////////////////////////////////////////////
  // Counter: an event in the clearing cycle still counts, so it reads 1
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      count_q <= `CMSC_WORD_RST;
    end else if (clear_in) begin
      count_q <= {15'h0000, event_in};
    end else if (event_in && (count_q != 16'hffff)) begin
      // Saturate rather than wrap, so a flood never reads as few faults
      count_q <= count_q + 16'h0001;
    end
  end

  assign count_out = count_q;

endmodule

// ==== verilog/cmsc_exchange.sv ====
// One explicit exchange: busy for a fixed number of cycles, then done.
// Assumes start and abort are single-cycle pulses.
`timescale 1ns/1ns

module cmsc_exchange
  import cmsc_pkg::*;
#(
  parameter logic [3:0] CYCLES = 4'h4   // Busy length in cycles
)
(
  input  wire logic clk_sys_in,   // System clock
  input  wire logic rst_in,       // Async reset, active high
  input  wire logic start_in,     // Exchange request, ignored while busy
  input  wire logic abort_in,     // Stop the exchange in progress
  output logic      busy_out,     // Exchange in progress
  output logic      done_out,     // Pulse: exchange ended normally
  output logic      failed_out    // Last exchange ended by abort
);

  cmsc_xstate_t state_q;   // Engine state
  logic [3:0]   left_q;    // Cycles still to run
  logic         failed_q;  // Sticky failure of last exchange
  logic         done_q;    // Normal end pulse

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= CMSC_XS_IDLE;
      left_q  <= 4'h0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        CMSC_XS_IDLE: begin
          // Abort in the start cycle wins: nothing begins
          if (start_in && !abort_in) begin
            state_q <= CMSC_XS_RUN;
            left_q  <= CYCLES;
          end
        end
        CMSC_XS_RUN: begin
          if (abort_in) begin
            state_q <= CMSC_XS_IDLE;
          end else if (left_q == 4'h1) begin
            state_q <= CMSC_XS_IDLE;
            done_q  <= 1'b1;
          end else begin
            left_q <= left_q - 4'h1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Failure report: set by an abort of a running exchange, kept until next start
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      failed_q <= 1'b0;
    end else if ((state_q == CMSC_XS_RUN) && abort_in) begin
      failed_q <= 1'b1;
    end else if ((state_q == CMSC_XS_IDLE) && start_in && !abort_in) begin
      failed_q <= 1'b0;
    end
  end

  assign busy_out   = (state_q == CMSC_XS_RUN);
  assign done_out   = done_q;
  assign failed_out = failed_q;

endmodule

// ==== verilog/cmsc_bank.sv ====
// Character-mode channel status and command register bank.
// Assumes a host that issues status-read and command-write exchanges,
// and all inputs synchronous to clk_sys_in.
`timescale 1ns/1ns

module cmsc_bank
  import cmsc_pkg::*;
(
  input  wire logic       clk_sys_in,                // System clock, 250 MHz
  input  wire logic       rst_in,                    // Async reset, active high
  // Character fault events from the serial datapath
  input  wire logic       tx_char_fault_in,          // Pulse: bad transmitted char
  input  wire logic       rx_char_fault_in,          // Pulse: bad received char
  // Fault sources
  input  wire logic       no_device_in,              // No device works on channel
  input  wire logic       partner_inoperative_in,    // One attached device is down
  input  wire logic       terminal_block_missing_in, // Terminal block unplugged
  input  wire logic       timeout_fault_in,          // Timeout seen
  input  wire logic       internal_fault_in,         // Internal fault
  input  wire logic       self_test_in,              // Channel self-test running
  input  wire logic       config_mismatch_fault_in,  // Hw/sw configuration differ
  input  wire logic       host_link_fault_in,        // Host communication fault
  input  wire logic       application_fault_in,      // Application fault
  // Modem lines, high while line voltage is positive
  input  wire logic       carrier_detect_in,         // Carrier detect line
  input  wire logic       clear_to_send_in,          // Clear-to-send line
  input  wire logic       set_ready_in,              // Data-set-ready line
  // Status read exchange
  input  wire logic       status_read_req_in,        // Pulse: start status read
  output cmsc_word_t      status_fault_out,          // Fault word read back
  output cmsc_word_t      status_protocol_out,       // Protocol word read back
  output logic            status_read_done_out,      // Pulse: read done, data valid next cycle
  // Command write exchange
  input  wire logic       command_req_in,            // Pulse: start command write
  input  wire cmsc_word_t command_word_in,           // Channel command word value
  output logic            command_done_out,          // Pulse: command applied
  // Implicit output word
  input  wire logic       output_word_we_in,         // Pulse: write output word
  input  wire cmsc_word_t output_word_in,            // Output command word value
  // Readable words
  output cmsc_word_t      tx_char_fault_count_out,   // Transmit fault counter
  output cmsc_word_t      rx_char_fault_count_out,   // Receive fault counter
  output cmsc_word_t      channel_command_word_out,  // Last accepted command
  output cmsc_word_t      output_command_word_out,   // Last written output word
  output cmsc_word_t      modem_input_lines_out,     // Sampled modem lines
  output cmsc_word_t      exchange_progress_word_out,// Exchange busy flags
  output cmsc_word_t      exchange_report_word_out,  // Exchange failure flags
  output logic            channel_error_flag_out,    // Any channel fault
  // Actions
  output logic            terminal_ready_out,        // Terminal-ready line
  output logic            halt_all_transfers_out,    // Pulse: stop all exchanges
  output logic            reboot_out                 // Pulse: reboot the module
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  // One word per readable register
  cmsc_word_t fault_q;          // Channel fault word
  cmsc_word_t fault_d;          // Its next value
  cmsc_word_t modem_q;          // Modem input word
  cmsc_word_t cmd_q;            // Last accepted channel command word
  cmsc_word_t out_q;            // Output command word
  cmsc_word_t sts_fault_q;      // Fault word captured by status read
  cmsc_word_t sts_proto_q;      // Protocol word captured by status read
  logic       ready_q;          // Terminal-ready line
  logic       halt_q;           // Halt pulse register
  logic       reboot_q;         // Reboot pulse register
  logic       soft_clr;         // Reboot or halt clears exchanges
  logic       count_clr;        // Counter clear this cycle
  logic       sts_busy;         // Status read running
  logic       sts_done;         // Status read ended normally
  logic       sts_failed;       // Status read aborted
  logic       cmd_busy;         // Command exchange running
  logic       cmd_done;         // Command exchange ended normally
  logic       cmd_failed;       // Command exchange aborted
  logic       halt_rise;        // Halt bit goes 0 to 1 in this write
  logic       reboot_hit;       // Reboot key written
  logic       ready_on;         // Terminal-ready set request
  logic       ready_off;        // Terminal-ready clear request
  logic [1:0] char_evt;         // Fault events, transmit then receive
  cmsc_word_t char_cnt [2];     // Counter values

  ////////////////////////////////////////////////////////////////////////
  // Output command word decode
  // Edge is taken against the stored word so a held bit never repeats
  assign halt_rise  = output_word_we_in && output_word_in[`CMSC_OB_HALT]
                      && !out_q[`CMSC_OB_HALT];
  assign reboot_hit = output_word_we_in && (output_word_in == `CMSC_REBOOT_KEY);

  // Abort any exchange on halt or reboot
  // Requests in that cycle are refused
  assign soft_clr = halt_q || reboot_q;

  // Output word store; reboot returns it to reset value
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      out_q <= `CMSC_WORD_RST;
    end else if (reboot_q) begin
      // Reboot wipes the stored key
      out_q <= `CMSC_WORD_RST;
    end else if (output_word_we_in) begin
      // Stored whether key or not
      out_q <= output_word_in;
    end
  end

  // Halt and reboot pulses, one cycle each
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      halt_q   <= 1'b0;
      reboot_q <= 1'b0;
    end else begin
      // Each lasts one cycle per write
      halt_q   <= halt_rise;
      reboot_q <= reboot_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Exchange engines
  // One shared abort for both engines
  // Status read: captures fault and protocol words at its end
  cmsc_exchange #(
    .CYCLES (4'(`CMSC_STS_CYCLES))
  ) u_sts_xchg (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .start_in   (status_read_req_in),
    .abort_in   (soft_clr),
    .busy_out   (sts_busy),
    .done_out   (sts_done),
    .failed_out (sts_failed)
  );

  // Command write: its delivery is the only path into command bits
  // Its word is captured apart, below
  cmsc_exchange #(
    .CYCLES (4'(`CMSC_CMD_CYCLES))
  ) u_cmd_xchg (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .start_in   (command_req_in),
    .abort_in   (soft_clr),
    .busy_out   (cmd_busy),
    .done_out   (cmd_done),
    .failed_out (cmd_failed)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command word capture at request, acted on only at delivery
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_q <= `CMSC_WORD_RST;
    end else if (reboot_q) begin
      cmd_q <= `CMSC_WORD_RST;
    end else if (command_req_in && !cmd_busy && !soft_clr) begin
      // Only when the engine takes it
      cmd_q <= command_word_in;
    end
  end

  // Command bits are one-shot requests on delivery
  assign count_clr = (cmd_done && cmd_q[`CMSC_CB_CLR_COUNT]) || reboot_q;
  assign ready_on  = cmd_done && cmd_q[`CMSC_CB_READY_ON];
  assign ready_off = cmd_done && cmd_q[`CMSC_CB_READY_OFF];

  // Terminal-ready line; both requests together leave it alone
  // Reboot beats any command
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ready_q <= 1'b0;
    end else if (reboot_q) begin
      // Reboot drops the line
      ready_q <= 1'b0;
    end else if (ready_on && !ready_off) begin
      ready_q <= 1'b1;
    end else if (ready_off && !ready_on) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Character fault counters, transmit at index 0, receive at index 1
  assign char_evt = {rx_char_fault_in, tx_char_fault_in};

  // Both counters share one clear
  generate
    for (genvar i = 0; i < 2; i++) begin : g_cnt
      cmsc_fault_counter u_cnt (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .event_in   (char_evt[i]),
        .clear_in   (count_clr),
        .count_out  (char_cnt[i])
      );
    end
  endgenerate

  assign tx_char_fault_count_out = char_cnt[0];
  assign rx_char_fault_count_out = char_cnt[1];

  ////////////////////////////////////////////////////////////////////////
  // Channel fault word, gathered combinationally, then registered
  // Upper bits read as zero
  always_comb begin
    fault_d                       = `CMSC_WORD_RST;
    fault_d[`CMSC_FB_NO_DEVICE]   = no_device_in;
    fault_d[`CMSC_FB_PARTNER]     = partner_inoperative_in;
    fault_d[`CMSC_FB_BLOCK]       = terminal_block_missing_in;
    fault_d[`CMSC_FB_TIMEOUT]     = timeout_fault_in;
    // Self-test reports as internal fault while it runs
    fault_d[`CMSC_FB_INTERNAL]    = internal_fault_in || self_test_in;
    fault_d[`CMSC_FB_CONFIG]      = config_mismatch_fault_in;
    fault_d[`CMSC_FB_HOST_LINK]   = host_link_fault_in;
    fault_d[`CMSC_FB_APPLICATION] = application_fault_in;
  end

  // Fault word and modem lines follow their sources, one cycle late
  // Registered so reads are glitch free
  // Unused modem bits stay zero
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      fault_q <= `CMSC_WORD_RST;
      modem_q <= `CMSC_WORD_RST;
    end else begin
      fault_q                      <= fault_d;
      modem_q                      <= `CMSC_WORD_RST;
      modem_q[`CMSC_MB_CARRIER]    <= carrier_detect_in;
      modem_q[`CMSC_MB_CLEAR_SEND] <= clear_to_send_in;
      modem_q[`CMSC_MB_SET_READY]  <= set_ready_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status read data, captured at the normal end of the read
  // Data lags the done pulse a cycle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sts_fault_q <= `CMSC_WORD_RST;
      sts_proto_q <= `CMSC_WORD_RST;
    end else if (sts_done) begin
      // Aborted reads keep old data
      sts_fault_q <= fault_q;
      sts_proto_q <= `CMSC_PROTOCOL_CHAR;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Progress and report words; adjustment bits are never driven high
  // Bits 15:3 read as zero
  always_comb begin
    exchange_progress_word_out                   = `CMSC_WORD_RST;
    exchange_progress_word_out[`CMSC_XB_STATUS]  = sts_busy;
    exchange_progress_word_out[`CMSC_XB_COMMAND] = cmd_busy;
    exchange_progress_word_out[`CMSC_XB_ADJUST]  = 1'b0;
    exchange_report_word_out                     = `CMSC_WORD_RST;
    exchange_report_word_out[`CMSC_XB_STATUS]    = sts_failed;
    exchange_report_word_out[`CMSC_XB_COMMAND]   = cmd_failed;
    exchange_report_word_out[`CMSC_XB_ADJUST]    = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // Plain wiring, mostly from flops
  assign status_fault_out         = sts_fault_q;
  assign status_protocol_out      = sts_proto_q;
  assign status_read_done_out     = sts_done;
  assign command_done_out         = cmd_done;
  assign channel_command_word_out = cmd_q;
  assign output_command_word_out  = out_q;
  assign modem_input_lines_out    = modem_q;
  assign channel_error_flag_out   = |fault_q;
  assign terminal_ready_out       = ready_q;
  assign halt_all_transfers_out   = halt_q;
  assign reboot_out               = reboot_q;

endmodule

// ==== verification/cmsc_bank_monitor.sv ====
// Checker of exchange timing and command effects at the bank ports.
// Assumes binding to cmsc_bank; one clock, async active-high reset.
`timescale 1ns/1ns
`include "cmsc_consts.svh"
module cmsc_bank_monitor
  import cmsc_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       tx_char_fault_in,
  input  wire logic       status_read_req_in,
  input  wire logic       status_read_done_out,
  input  wire logic       command_req_in,
  input  wire logic       command_done_out,
  input  wire logic       output_word_we_in,
  input  wire cmsc_word_t output_word_in,
  input  wire cmsc_word_t tx_char_fault_count_out,
  input  wire cmsc_word_t channel_command_word_out,
  input  wire cmsc_word_t output_command_word_out,
  input  wire cmsc_word_t exchange_progress_word_out,
  input  wire cmsc_word_t exchange_report_word_out,
  input  wire logic       terminal_ready_out,
  input  wire logic       halt_all_transfers_out,
  input  wire logic       reboot_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Short aliases; stop covers both pulses that abort exchanges
  wire cmsc_word_t ep   = exchange_progress_word_out;
  wire cmsc_word_t er   = exchange_report_word_out;
  wire cmsc_word_t cw   = channel_command_word_out;
  wire cmsc_word_t ow   = output_command_word_out;
  wire logic       stop = halt_all_transfers_out | reboot_out;
  // Four busy cycles, then the done pulse with busy already low
  sequence s_sts_run;
    ep[0] [*4] ##1 (status_read_done_out && !ep[0]);
  endsequence
  sequence s_cmd_run;
    ep[1] [*4] ##1 (command_done_out && !ep[1]);
  endsequence
  ////////////////////////////////////////////////////////////////////
  sts_walk_a: assert property (disable iff (rst_in || stop)
    status_read_req_in && !ep[0] && !stop |=> s_sts_run) else $error("status read timing wrong");
  cmd_walk_a: assert property (disable iff (rst_in || stop)
    command_req_in && !ep[1] && !stop |=> s_cmd_run) else $error("command exchange timing wrong");
  halt_abort_a: assert property (halt_all_transfers_out |=> ep[1:0] == 2'b00 &&
    (er[1:0] & $past(ep[1:0])) == $past(ep[1:0])) else $error("abort not reported");
  halt_edge_a: assert property (output_word_we_in |=> halt_all_transfers_out ==
    ($past(output_word_in[0]) && !$past(ow[0]))) else $error("halt pulse wrong");
  reboot_key_a: assert property (output_word_we_in && output_word_in == `CMSC_REBOOT_KEY
    |=> reboot_out ##1 (ow == `CMSC_WORD_RST && cw == `CMSC_WORD_RST && !terminal_ready_out))
    else $error("reboot not carried out");
  adjust_zero_a: assert property (!ep[2] && !er[2]) else $error("adjust flag set");
  ready_cmd_a: assert property (disable iff (rst_in || reboot_out)
    command_done_out && !reboot_out |=> terminal_ready_out ==
    (($past(cw[8]) ^ $past(cw[9])) ? $past(cw[8]) : $past(terminal_ready_out)))
    else $error("terminal ready wrong after command");
  ready_hold_a: assert property (!command_done_out && !reboot_out
    |=> $stable(terminal_ready_out)) else $error("terminal ready moved without command");
  count_clear_a: assert property (command_done_out && cw[0] && !tx_char_fault_in
    |=> tx_char_fault_count_out == 16'h0000) else $error("counter not cleared");
endmodule
bind cmsc_bank cmsc_bank_monitor u_cmsc_bank_monitor (.*);

// ==== verification/cmsc_host_model.sv ====
// Host model: status reads, command writes and output word writes.
// Assumes the bank answers with one-cycle done pulses on clk_sys_in.
`timescale 1ns/1ns
module cmsc_host_model
  import cmsc_pkg::*;
(
  input  wire logic       clk_sys_in,          // System clock
  input  wire logic       status_read_done_in, // Status read finished
  input  wire logic       command_done_in,     // Command applied
  output logic            status_read_req_out, // Status read request
  output logic            command_req_out,     // Command write request
  output cmsc_word_t      command_word_out,    // Command word value
  output logic            output_word_we_out,  // Output word write
  output cmsc_word_t      output_word_out      // Output word value
);
  // Idle at time zero, no request pending
  initial begin
    {status_read_req_out, command_req_out, output_word_we_out} = 3'h0;
    {command_word_out, output_word_out} = 32'hffff_ffff;
  end
  // Fault words are only fetched, and commands only given, by exchange
  task automatic exchange(input logic cmd, input cmsc_word_t w, output logic ok);
    ok = 1'b0;
    @(posedge clk_sys_in);
    status_read_req_out <= !cmd;
    command_req_out     <= cmd;
    command_word_out    <= w;
    @(posedge clk_sys_in);
    {status_read_req_out, command_req_out} <= 2'h0;
    // Data is no longer qualified: show the inverse, not a stale copy
    command_word_out    <= ~w;
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clk_sys_in);
      ok = cmd ? command_done_in : status_read_done_in;
    end
    @(posedge clk_sys_in);
  endtask
  // Single-cycle write of the output command word
  task automatic output_write(input cmsc_word_t w);
    @(posedge clk_sys_in);
    output_word_we_out <= 1'b1;
    output_word_out    <= w;
    @(posedge clk_sys_in);
    output_word_we_out <= 1'b0;
    output_word_out    <= ~w;
  endtask
endmodule

// ==== verification/cmsc_bank_tb.sv ====
// Self-checking bench for the channel status and command bank.
// Assumes the checker and host model files are compiled before it.
`timescale 1ns/1ns
`include "cmsc_consts.svh"
module cmsc_bank_tb
  import cmsc_pkg::*;
;
  logic       clk_sys_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       tx_char_fault_in, rx_char_fault_in, status_read_req_in, command_req_in, ok;
  logic       output_word_we_in, status_read_done_out, command_done_out, reboot_out;
  logic       channel_error_flag_out, terminal_ready_out, halt_all_transfers_out;
  logic       no_device_in, partner_inoperative_in, terminal_block_missing_in, self_test_in;
  logic       timeout_fault_in, internal_fault_in, config_mismatch_fault_in, host_link_fault_in;
  logic       application_fault_in, carrier_detect_in, clear_to_send_in, set_ready_in;
  cmsc_word_t command_word_in, output_word_in, status_fault_out, status_protocol_out;
  cmsc_word_t tx_char_fault_count_out, rx_char_fault_count_out, channel_command_word_out;
  cmsc_word_t output_command_word_out, modem_input_lines_out, exchange_progress_word_out;
  cmsc_word_t exchange_report_word_out;
  logic [8:0] flt;            // Fault sources, no-device first
  logic [2:0] modem;          // Carrier, clear-send, set-ready
  int         errors = 0;
  int         tests_run = 0;
  // Command table and the terminal-ready level each leaves behind
  cmsc_word_t cmds [5] = '{16'h0100, 16'h0300, 16'h0200, 16'h0300, 16'h0100};
  logic       rdy  [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  assign {application_fault_in, host_link_fault_in, config_mismatch_fault_in, self_test_in,
          internal_fault_in, timeout_fault_in, terminal_block_missing_in,
          partner_inoperative_in, no_device_in} = flt;
  assign {set_ready_in, clear_to_send_in, carrier_detect_in} = modem;
  always #2 clk_sys_in = ~clk_sys_in;
  cmsc_bank u_cmsc_bank (.*);
  cmsc_host_model u_host (
    .clk_sys_in (clk_sys_in), .status_read_done_in (status_read_done_out),
    .command_done_in (command_done_out), .status_read_req_out (status_read_req_in),
    .command_req_out (command_req_in), .command_word_out (command_word_in),
    .output_word_we_out (output_word_we_in), .output_word_out (output_word_in));
  ////////////////////////////////////////////////////////////////////
  // Word compare; bits go through it zero-extended
  task automatic chk_w(input cmsc_word_t got, input cmsc_word_t exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {flt, modem, tx_char_fault_in, rx_char_fault_in} = '0;
    repeat (8) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    // Each fault source alone; self-test shares the internal bit
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_sys_in) flt <= 9'h001 << i;
      u_host.exchange(1'b0, 16'h0000, ok);
      chk_b(ok, 1'b1);
      chk_w(status_fault_out, 16'h0001 << (i < 5 ? i : i - 1));
      chk_b(channel_error_flag_out, 1'b1);
    end
    chk_w(status_protocol_out, `CMSC_PROTOCOL_CHAR);
    @(posedge clk_sys_in) flt <= 9'h000;
    repeat (3) @(posedge clk_sys_in);
    chk_b(channel_error_flag_out, 1'b0);
    // All eight modem line combinations
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys_in) modem <= i[2:0];
      repeat (3) @(posedge clk_sys_in);
      chk_w(modem_input_lines_out, {12'h000, i[2:1], 1'b0, i[0]});
    end
    // Three transmit and five receive faults, then a counter clear
    @(posedge clk_sys_in) {tx_char_fault_in, rx_char_fault_in} <= 2'b11;
    repeat (3) @(posedge clk_sys_in);
    tx_char_fault_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rx_char_fault_in <= 1'b0;
    @(posedge clk_sys_in);
    chk_w(tx_char_fault_count_out, 16'h0003);
    chk_w(rx_char_fault_count_out, 16'h0005);
    u_host.exchange(1'b1, 16'h0001, ok);
    chk_w(tx_char_fault_count_out | rx_char_fault_count_out, 16'h0000);
    // Terminal-ready set, both bits, clear
    for (int i = 0; i < 5; i++) begin
      u_host.exchange(1'b1, cmds[i], ok);
      chk_b(terminal_ready_out, rdy[i]);
      chk_w(channel_command_word_out, cmds[i]);
    end
    // Halt in mid-exchange: status read, then command write
    for (int k = 0; k < 2; k++) begin
      u_host.output_write(16'h0000);
      fork
        u_host.exchange(k[0], 16'h0000, ok);
        begin
          repeat (2) @(posedge clk_sys_in);
          u_host.output_write(16'h0001);
        end
      join
      chk_b(ok, 1'b0);
      chk_w(exchange_report_word_out, {14'h0000, k[0], 1'b1});
    end
    // Reboot key with terminal ready up
    u_host.exchange(1'b1, 16'h0100, ok);
    u_host.output_write(`CMSC_REBOOT_KEY);
    #1 chk_b(reboot_out, 1'b1);
    @(posedge clk_sys_in);
    #1 chk_w(channel_command_word_out | output_command_word_out, 16'h0000);
    chk_b(terminal_ready_out, 1'b0);
    finish_test;
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    errors++;
    finish_test;
  end
endmodule
